// *** hdl/smc_measure_ctrl.sv ***
// Purpose: control, status and source selection of a 24-bit signal measurement timer
// Assumes: one 10 MHz clock; clock sources arrive as sampled levels
// Notes: register read data stand one cycle after the read strobe
// Operation
// - enable low resets internal state and drops the clock request
// - enable low leaves every software-visible register untouched except the acquiring, window and counting status bits, which clear
// - on period match hold or clear per halt bit, match pulse follows
// - window polarity 1 means active low, falling edges
// - signal polarity 1 means active low, falling edges
// - clock polarity picks rising or falling counting edge
// - prescale code divides by 1, 2, 4 or 8
// - run bit permits counting; hardware clears it when a single run ends
// - repeat bit chooses continuous or single acquisition
// - four-bit mode field with eleven codes, rest reserved
// - period update request loads captured period, then self-clears
// - width update request loads captured width, then self-clears
// - reset request clears the counter, then self-clears
// - counting status shows the counter is incrementing
// - window status shows the window is open
// - acquiring status shows a measurement in progress
// - three-bit clock select picks one of eight counting clocks
// - five-bit window select, codes 27 and up reserved
// - five-bit signal select, codes 26 and up reserved
// - every field resets to zero except period, which resets to all ones; unimplemented bits read zero
// - timer mode clears, or holds at period when the halt bit is set, on period match and signals it
// - counter modes count signal edges, others the selected clock
// - counter, period and captures are 24 bits in three bytes
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "smc_consts.svh"
module smc_measure_ctrl (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // register port
  input smc_pkg::smc_bus_req_s i_bus,
  output logic [7:0] o_rdata,
  // sources
  input wire logic [7:0] i_clk_src,
  input wire logic [31:0] i_win_src,
  input wire logic [31:0] i_sig_src,
  // events and requests
  output logic o_clk_req,
  output logic o_period_match,
  output logic o_pr_capture,
  output logic o_pw_capture
);
  import smc_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [2:0] presc_last(input logic [1:0] code);
    presc_last = 3'((4'h1 << code) - 4'h1);
  endfunction

  function automatic logic hit3(input logic [4:0] addr, input logic [4:0] base);
    hit3 = (addr >= base) && (addr < 5'(base + 5'h3));
  endfunction

  function automatic logic [7:0] byte_of(input logic [23:0] v, input logic [1:0] k);
    byte_of = v[8*k +: 8];
  endfunction

  function automatic logic [23:0] put_byte(input logic [23:0] v, input logic [1:0] k,
                                           input logic [7:0] b);
    logic [23:0] r;
    r = v;
    r[8*k +: 8] = b;
    put_byte = r;
  endfunction

  // per-mode reaction to the current edges
  function automatic smc_act_s mode_act(input logic [3:0] mode, input logic tick,
                                        input smc_edge_s w, input smc_edge_s s);
    smc_act_s a;
    a = '0;
    unique case (mode)
      SMC_MODE_TIMER: a.inc = tick;
      SMC_MODE_GATED_TIMER: begin
        a.inc = tick & s.act;
        a.pw_ev = s.fall;
      end
      SMC_MODE_PERIOD_DUTY: begin
        a.inc = tick;
        a.pw_ev = s.fall;
        a.pr_ev = s.rise;
        a.clr_on_pr = 1'b1;
      end
      SMC_MODE_HIGH_LOW: begin
        a.wait_start = 1'b1;
        a.start = s.rise;
        a.inc = tick;
        a.pw_ev = s.fall;
        a.pr_ev = s.rise;
        a.clr_on_pr = 1'b1;
        a.clr_on_pw = 1'b1;
      end
      SMC_MODE_WIN_MEASURE: begin
        a.wait_start = 1'b1;
        a.start = w.rise;
        a.inc = tick;
        a.pr_ev = w.rise;
        a.clr_on_pr = 1'b1;
      end
      SMC_MODE_GATED_WIN: begin
        a.wait_start = 1'b1;
        a.start = w.rise;
        a.inc = tick & s.act;
        a.pr_ev = w.rise;
        a.clr_on_pr = 1'b1;
      end
      SMC_MODE_FLIGHT: begin
        a.wait_start = 1'b1;
        a.start = w.rise;
        a.inc = tick;
        a.pr_ev = s.rise;
        a.pw_ev = w.rise & ~s.rise;
        a.clr_on_pr = 1'b1;
        a.clr_on_pw = 1'b1;
      end
      SMC_MODE_CAPTURE: begin
        a.inc = tick;
        a.pr_ev = w.rise;
        a.pw_ev = w.fall;
      end
      SMC_MODE_COUNTER: begin
        a.inc = s.rise;
        a.pw_ev = w.rise;
      end
      SMC_MODE_GATED_COUNTER: begin
        a.wait_start = 1'b1;
        a.start = w.rise;
        a.inc = s.rise & w.act;
        a.pw_ev = w.fall;
      end
      SMC_MODE_WIN_COUNTER: begin
        a.wait_start = 1'b1;
        a.start = w.rise;
        a.inc = s.rise;
        a.pw_ev = w.fall;
        a.pr_ev = w.rise;
      end
      default: a = '0; // reserved codes do nothing
    endcase
    mode_act = a;
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] ctrl_a;
  logic [7:0] ctrl_b;
  logic [2:0] upd_req;
  logic [7:0] clk_sel;
  logic [7:0] win_sel;
  logic [7:0] sig_sel;
  logic [23:0] counter;
  logic [23:0] period;
  logic [23:0] cap_period;
  logic [23:0] cap_width;
  logic [2:0] presc_cnt;
  logic counting;
  smc_state_e state;
  smc_state_e next_state;
  logic [23:0] next_counter;

  // ----------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------
  wire logic en = ctrl_a[`SMC_BIT_EN];
  wire logic halt = ctrl_a[`SMC_BIT_HALT];
  wire logic go = ctrl_b[`SMC_BIT_GO];
  wire logic repeat_on = ctrl_b[`SMC_BIT_REPEAT];
  wire logic [3:0] mode = ctrl_b[3:0];
  wire logic async_mode = mode[3];
  wire logic wr = i_bus.wr;
  wire logic [4:0] addr = i_bus.addr;
  wire logic [1:0] cnt_k = 2'(addr - `SMC_OFS_COUNTER);
  wire logic [1:0] per_k = 2'(addr - `SMC_OFS_PERIOD);
  wire logic wr_a = wr && addr == `SMC_OFS_CTRL_A;
  wire logic wr_b = wr && addr == `SMC_OFS_CTRL_B;
  wire logic wr_st = wr && addr == `SMC_OFS_STATUS;
  wire logic wr_cnt = wr && hit3(addr, `SMC_OFS_COUNTER);
  wire logic wr_per = wr && hit3(addr, `SMC_OFS_PERIOD);

  // ----------------------------------------------------------------
  // source selection
  // ----------------------------------------------------------------
  smc_edge_s clk_e;
  smc_edge_s win_e;
  smc_edge_s sig_e;
  // the counting edge is the rising edge of clock xor polarity
  smc_src_sync #(.NUM_SRC(`SMC_NUM_CLK)) u_clk_sel (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_src({24'h000000, i_clk_src}),
    .i_code({2'h0, clk_sel[2:0]}),
    .i_pol(ctrl_a[`SMC_BIT_CLOCK_EDGE_POLARITY]),
    .o_edge(clk_e)
  );
  smc_src_sync #(.NUM_SRC(`SMC_NUM_WIN)) u_win_sel (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_src(i_win_src),
    .i_code(win_sel[4:0]),
    .i_pol(ctrl_a[`SMC_BIT_WINDOW_POLARITY]),
    .o_edge(win_e)
  );
  smc_src_sync #(.NUM_SRC(`SMC_NUM_SIG)) u_sig_sel (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_src(i_sig_src),
    .i_code(sig_sel[4:0]),
    .i_pol(ctrl_a[`SMC_BIT_SIGNAL_POLARITY]),
    .o_edge(sig_e)
  );

  // ----------------------------------------------------------------
  // timing and mode actions
  // ----------------------------------------------------------------
  wire logic presc_wrap = (presc_cnt == presc_last(ctrl_a[1:0]));
  wire logic tick = en && !async_mode && clk_e.rise && presc_wrap;
  wire smc_act_s act = mode_act(mode, tick, win_e, sig_e);
  wire logic live = en && go;
  wire logic running = live && state == SMC_ST_RUN;
  wire logic inc = running && act.inc;
  wire logic match = (counter == period);
  wire logic pr_ev = running && act.pr_ev;
  wire logic pw_ev = running && act.pw_ev;
  wire logic done = (pr_ev || pw_ev) && !repeat_on;
  wire logic start_ev = live && state == SMC_ST_ARMED && act.start;
  wire logic pr_upd = en && upd_req[2];
  wire logic pw_upd = en && upd_req[1];
  wire logic rst_upd = en && upd_req[0];
  wire logic restart = (pr_ev && act.clr_on_pr) || (pw_ev && act.clr_on_pw);
  wire logic [23:0] restart_val = (mode == SMC_MODE_PERIOD_DUTY && pr_ev) ?
                                  `SMC_DUTY_RESTART : `SMC_RST_COUNT;

  // acquisition sequence: idle, armed for a start edge, running
  always_comb begin
    next_state = state;
    unique case (state)
      SMC_ST_IDLE: if (live) begin
        next_state = act.wait_start ? SMC_ST_ARMED : SMC_ST_RUN;
      end
      SMC_ST_ARMED: if (start_ev) begin
        next_state = SMC_ST_RUN;
      end
      SMC_ST_RUN: if (done) begin
        next_state = SMC_ST_IDLE;
      end
      default: next_state = SMC_ST_IDLE;
    endcase
    if (!live) begin
      next_state = SMC_ST_IDLE;
    end
  end

  // counter source priority: software byte, manual reset, start edge, restart, count
  always_comb begin
    next_counter = counter;
    if (wr_cnt) begin
      next_counter = put_byte(counter, cnt_k, i_bus.wdata);
    end else if (rst_upd) begin
      next_counter = `SMC_RST_COUNT;
    end else if (start_ev) begin
      next_counter = `SMC_RST_COUNT;
    end else if (restart) begin
      next_counter = restart_val;
    end else if (inc) begin
      next_counter = match ? (halt ? period : `SMC_RST_COUNT) : 24'(counter + 24'h1);
    end
  end

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  // prescaler and sequence clear while disabled
  always_ff @(posedge i_clk) begin
    if (!i_rst_b || !en) begin
      presc_cnt <= 3'h0;
      state <= SMC_ST_IDLE;
    end else begin
      if (clk_e.rise && !async_mode) begin
        presc_cnt <= presc_wrap ? 3'h0 : 3'(presc_cnt + 3'h1);
      end
      state <= next_state;
    end
  end

  // counter and period registers survive disable
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      counter <= `SMC_RST_COUNT;
      period <= `SMC_RST_PERIOD;
    end else begin
      counter <= next_counter;
      if (wr_per) begin
        period <= put_byte(period, per_k, i_bus.wdata);
      end
    end
  end

  // captured latches: mode events and manual updates
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      cap_period <= `SMC_RST_COUNT;
      cap_width <= `SMC_RST_COUNT;
    end else begin
      if (pr_ev || pr_upd) begin
        cap_period <= counter;
      end
      if (pw_ev || pw_upd) begin
        cap_width <= counter;
      end
    end
  end

  // control registers; software set of the run bit wins over hardware clear
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      ctrl_a <= `SMC_RST_BYTE;
      ctrl_b <= `SMC_RST_BYTE;
      clk_sel <= `SMC_RST_BYTE;
      win_sel <= `SMC_RST_BYTE;
      sig_sel <= `SMC_RST_BYTE;
    end else begin
      if (wr_a) begin
        ctrl_a <= i_bus.wdata & `SMC_MASK_CTRL_A;
      end
      if (wr_b) begin
        ctrl_b <= i_bus.wdata & `SMC_MASK_CTRL_B;
      end else if (en && done) begin
        ctrl_b[`SMC_BIT_GO] <= 1'b0;
      end
      if (wr && addr == `SMC_OFS_CLK_SEL) begin
        clk_sel <= i_bus.wdata & `SMC_MASK_CLK_SEL;
      end
      if (wr && addr == `SMC_OFS_WIN_SEL) begin
        win_sel <= i_bus.wdata & `SMC_MASK_SRC_SEL;
      end
      if (wr && addr == `SMC_OFS_SIG_SEL) begin
        sig_sel <= i_bus.wdata & `SMC_MASK_SRC_SEL;
      end
    end
  end

  // update requests: a software write of 1 wins over the hardware clear
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      upd_req <= 3'h0;
    end else if (wr_st) begin
      upd_req <= i_bus.wdata[`SMC_BIT_PR_UPD:`SMC_BIT_RST_REQ] | (upd_req & ~{pr_upd, pw_upd,
                 rst_upd});
    end else begin
      upd_req <= upd_req & ~{pr_upd, pw_upd, rst_upd};
    end
  end

  // ----------------------------------------------------------------
  // read path and outputs
  // ----------------------------------------------------------------
  wire logic [7:0] status_byte = {upd_req, 2'h0, counting, win_e.act && en,
                                  state != SMC_ST_IDLE};
  wire logic [7:0] rd_mux =
    (addr == `SMC_OFS_CTRL_A) ? ctrl_a :
    (addr == `SMC_OFS_CTRL_B) ? ctrl_b :
    (addr == `SMC_OFS_STATUS) ? status_byte :
    (addr == `SMC_OFS_CLK_SEL) ? clk_sel :
    (addr == `SMC_OFS_WIN_SEL) ? win_sel :
    (addr == `SMC_OFS_SIG_SEL) ? sig_sel :
    hit3(addr, `SMC_OFS_COUNTER) ? byte_of(counter, cnt_k) :
    hit3(addr, `SMC_OFS_PERIOD) ? byte_of(period, per_k) :
    hit3(addr, `SMC_OFS_CAP_PERIOD) ? byte_of(cap_period, 2'(addr - `SMC_OFS_CAP_PERIOD)) :
    hit3(addr, `SMC_OFS_CAP_WIDTH) ? byte_of(cap_width, 2'(addr - `SMC_OFS_CAP_WIDTH)) :
    8'h00; // unmapped reads zero

  // registered outputs
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_rdata <= 8'h00;
      o_clk_req <= 1'b0;
      o_period_match <= 1'b0;
      o_pr_capture <= 1'b0;
      o_pw_capture <= 1'b0;
      counting <= 1'b0;
    end else begin
      o_rdata <= i_bus.rd ? rd_mux : 8'h00;
      o_clk_req <= en && go;
      o_period_match <= inc && match;
      o_pr_capture <= pr_ev || pr_upd;
      o_pw_capture <= pw_ev || pw_upd;
      counting <= inc;
    end
  end
endmodule

// *** include/smc_consts.svh ***
// Purpose: offsets, field positions, reset values and masks of the measure timer control
// Assumes: byte-wide register port, 5-bit address
// Notes: definitions only
`ifndef SMC_CONSTS_SVH
`define SMC_CONSTS_SVH
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SMC_OFS_CTRL_A 5'h00
`define SMC_OFS_CTRL_B 5'h01
`define SMC_OFS_STATUS 5'h02
`define SMC_OFS_CLK_SEL 5'h03
`define SMC_OFS_WIN_SEL 5'h04
`define SMC_OFS_SIG_SEL 5'h05
`define SMC_OFS_COUNTER 5'h06
`define SMC_OFS_PERIOD 5'h09
`define SMC_OFS_CAP_PERIOD 5'h0C
`define SMC_OFS_CAP_WIDTH 5'h0F
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SMC_BIT_EN 7
`define SMC_BIT_HALT 5
`define SMC_BIT_WINDOW_POLARITY 4
`define SMC_BIT_SIGNAL_POLARITY 3
`define SMC_BIT_CLOCK_EDGE_POLARITY 2
`define SMC_BIT_GO 7
`define SMC_BIT_REPEAT 6
`define SMC_BIT_PR_UPD 7
`define SMC_BIT_PW_UPD 6
`define SMC_BIT_RST_REQ 5
`define SMC_BIT_TS 2
`define SMC_BIT_WS 1
`define SMC_BIT_AS 0
// ----------------------------------------------------------------
// writable masks and reset values
// ----------------------------------------------------------------
`define SMC_MASK_CTRL_A 8'hBF
`define SMC_MASK_CTRL_B 8'hCF
`define SMC_MASK_CLK_SEL 8'h07
`define SMC_MASK_SRC_SEL 8'h1F
`define SMC_RST_BYTE 8'h00
`define SMC_RST_COUNT 24'h000000
`define SMC_RST_PERIOD 24'hFFFFFF
`define SMC_DUTY_RESTART 24'h000001
// ----------------------------------------------------------------
// source counts (codes at or above are reserved)
// ----------------------------------------------------------------
`define SMC_NUM_CLK 8
`define SMC_NUM_WIN 27
`define SMC_NUM_SIG 26
`endif

// *** include/smc_pkg.sv ***
// Purpose: types shared by the measure timer control files
// Assumes: nothing
// Notes: constants live in smc_consts.svh
package smc_pkg;
  typedef enum logic [3:0] {
    SMC_MODE_TIMER = 4'h0,
    SMC_MODE_GATED_TIMER = 4'h1,
    SMC_MODE_PERIOD_DUTY = 4'h2,
    SMC_MODE_HIGH_LOW = 4'h3,
    SMC_MODE_WIN_MEASURE = 4'h4,
    SMC_MODE_GATED_WIN = 4'h5,
    SMC_MODE_FLIGHT = 4'h6,
    SMC_MODE_CAPTURE = 4'h7,
    SMC_MODE_COUNTER = 4'h8,
    SMC_MODE_GATED_COUNTER = 4'h9,
    SMC_MODE_WIN_COUNTER = 4'hA
  } smc_mode_e;
  typedef enum logic [1:0] {
    SMC_ST_IDLE = 2'b00,
    SMC_ST_ARMED = 2'b01,
    SMC_ST_RUN = 2'b11
  } smc_state_e;
  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } smc_bus_req_s;
  typedef struct packed {
    logic act;
    logic rise;
    logic fall;
  } smc_edge_s;
  typedef struct packed {
    logic wait_start;
    logic start;
    logic inc;
    logic pr_ev;
    logic pw_ev;
    logic clr_on_pr;
    logic clr_on_pw;
  } smc_act_s;
endpackage

// *** hdl/smc_src_sync.sv ***
// Purpose: picks one source by code, synchronises it and finds its active edges
// Assumes: sources are levels, sampled on i_clk
// Notes: reserved codes give a quiet low source
`timescale 1ns/1ps
`include "smc_consts.svh"
module smc_src_sync #(
  parameter int NUM_SRC = 32
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // source choice
  input wire logic [31:0] i_src,
  input wire logic [4:0] i_code,
  input wire logic i_pol,
  // result
  output smc_pkg::smc_edge_s o_edge
);
  import smc_pkg::*;
  logic sync_meta;
  logic sync_lvl;
  logic prev_lvl;
  wire logic code_ok = (32'(i_code) < NUM_SRC);
  wire logic picked = code_ok & i_src[i_code];
  wire logic act_now = sync_lvl ^ i_pol;
  wire logic act_prev = prev_lvl ^ i_pol;
  // two-stage synchroniser, third stage only for edge history
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      sync_meta <= 1'b0;
      sync_lvl <= 1'b0;
      prev_lvl <= 1'b0;
    end else begin
      sync_meta <= picked;
      sync_lvl <= sync_meta;
      prev_lvl <= sync_lvl;
    end
  end
  // polarity folds falling edges onto the active edge
  assign o_edge.act = act_now;
  assign o_edge.rise = act_now & ~act_prev;
  assign o_edge.fall = ~act_now & act_prev;
endmodule

// *** sim/smc_src_model.sv ***
// Purpose: source side model for the measure timer control
// Assumes: one clock; clock sources are free-running oscillators
// Notes: unselected lines carry the inverse of the live level
`timescale 1ns/1ps
module smc_src_model (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // levels to present
  input wire logic [4:0] i_win_code,
  input wire logic i_win_lvl,
  input wire logic [4:0] i_sig_code,
  input wire logic i_sig_lvl,
  // sources
  output logic [7:0] o_clk_src,
  output logic [31:0] o_win_src,
  output logic [31:0] o_sig_src
);
  logic [8:0] div;
  // source k toggles every 2^(k+1) cycles
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      div <= 9'h000;
    end else begin
      div <= div + 9'h001;
    end
  end
  assign o_clk_src = div[8:1];
  // selected line shows the level, others its inverse
  always_comb begin
    o_win_src = {32{~i_win_lvl}};
    o_win_src[i_win_code] = i_win_lvl;
    o_sig_src = {32{~i_sig_lvl}};
    o_sig_src[i_sig_code] = i_sig_lvl;
  end
endmodule

// *** sim/smc_measure_ctrl_assertions.sv ***
// Purpose: port checker for the measure timer control
// Assumes: shadows track software writes to hardware-stable registers
// Notes: bound from the testbench file
`timescale 1ns/1ps
module smc_measure_ctrl_chk (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // register port
  input smc_pkg::smc_bus_req_s i_bus,
  input wire logic [7:0] o_rdata,
  // events
  input wire logic o_clk_req,
  input wire logic o_period_match,
  input wire logic o_pr_capture,
  input wire logic o_pw_capture
);
  import smc_pkg::*;
  logic [7:0] sh_a, sh_clk, sh_win, sh_sig;
  logic sh_en;
  // shadow copies of registers only software changes
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      sh_a <= 8'h00;
      sh_clk <= 8'h00;
      sh_win <= 8'h00;
      sh_sig <= 8'h00;
    end else if (i_bus.wr) begin
      case (i_bus.addr)
        5'h00: sh_a <= i_bus.wdata & 8'hBF;
        5'h03: sh_clk <= i_bus.wdata & 8'h07;
        5'h04: sh_win <= i_bus.wdata & 8'h1F;
        5'h05: sh_sig <= i_bus.wdata & 8'h1F;
        default: ;
      endcase
    end
  end
  assign sh_en = sh_a[7];
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  sequence s_rd(logic [4:0] a);
    i_bus.rd && i_bus.addr == a;
  endsequence
  a_ctrl_a_read: assert property (s_rd(5'h00) |=> o_rdata == $past(sh_a))
    else $error("control_a readback differs");
  a_clk_sel_read: assert property (s_rd(5'h03) |=> o_rdata == $past(sh_clk))
    else $error("clock select readback differs");
  a_win_sel_read: assert property (s_rd(5'h04) |=> o_rdata == $past(sh_win))
    else $error("window select readback differs");
  a_sig_sel_read: assert property (s_rd(5'h05) |=> o_rdata == $past(sh_sig))
    else $error("signal select readback differs");
  a_status_gaps: assert property (s_rd(5'h02) |=> o_rdata[4:3] == 2'b00)
    else $error("status gap bits not zero");
  a_ctrl_b_gaps: assert property (s_rd(5'h01) |=> o_rdata[5:4] == 2'b00)
    else $error("control_b gap bits not zero");
  a_unmapped_zero: assert property (i_bus.rd && i_bus.addr > 5'h11 |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_req_needs_en: assert property (o_clk_req |-> $past(sh_en))
    else $error("clock request while disabled");
  a_match_needs_run: assert property (o_period_match |-> $past(o_clk_req))
    else $error("period match while stopped");
  a_pr_needs_en: assert property (o_pr_capture |-> $past(sh_en))
    else $error("period capture while disabled");
  a_pw_needs_en: assert property (o_pw_capture |-> $past(sh_en))
    else $error("width capture while disabled");
endmodule

// *** sim/testbench.sv ***
// Purpose: self-checking bench for the measure timer control
// Assumes: 10 MHz clock, synchronous active-low reset
// Notes: one task per scenario
`timescale 1ns/1ps
module testbench;
  import smc_pkg::*;
  logic i_clk, i_rst_b, clk_req, pmatch, prcap, pwcap, wlvl, slvl;
  smc_bus_req_s bus;
  logic [7:0] rdata, clk_src;
  logic [31:0] win_src, sig_src;
  logic [4:0] wcode, scode;
  logic [2:0] ev;
  int err_total, n_tests;
  assign ev = {pwcap, prcap, pmatch};
  smc_measure_ctrl smc_measure_ctrl_i (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_bus(bus),
    .o_rdata(rdata), .i_clk_src(clk_src), .i_win_src(win_src), .i_sig_src(sig_src),
    .o_clk_req(clk_req), .o_period_match(pmatch), .o_pr_capture(prcap),
    .o_pw_capture(pwcap));
  smc_src_model smc_src_model_i (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_win_code(wcode),
    .i_win_lvl(wlvl), .i_sig_code(scode), .i_sig_lvl(slvl), .o_clk_src(clk_src),
    .o_win_src(win_src), .o_sig_src(sig_src));
  // ------
  // bus and check tasks
  // ------
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge i_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk);
    bus <= '0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge i_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk);
    bus <= '0;
    #1 d = rdata;
  endtask
  task automatic rd24(input logic [4:0] a, output logic [23:0] v);
    rd(a, v[7:0]);
    rd(a + 5'h01, v[15:8]);
    rd(a + 5'h02, v[23:16]);
  endtask
  // wait for one event pulse, bounded
  task automatic wait_ev(input int which, output int n);
    n = 0;
    do begin
      @(posedge i_clk);
      #1 n++;
    end while (ev[which] !== 1'b1 && n < 2000);
  endtask
  // ------
  // scenarios
  // ------
  task automatic t_regs;
    logic [7:0] b;
    logic [23:0] v;
    for (int a = 0; a < 6; a++) begin
      rd(5'(a), b);
      chk("reset byte", 24'h0, 24'(b));
    end
    rd24(5'h09, v);
    chk("period reset", 24'hFFFFFF, v);
    for (int m = 0; m < 11; m++) begin
      wr(5'h01, 8'(m));
      rd(5'h01, b);
      chk("mode code", 24'(m), 24'(b));
    end
    wr(5'h01, 8'h00);
    for (int a = 0; a < 6; a++) begin
      wr(5'(a), 8'hFF);
    end
    rd(5'h00, b);
    chk("control_a mask", 24'hBF, 24'(b));
    rd(5'h01, b);
    chk("control_b mask", 24'hCF, 24'(b));
    rd(5'h03, b);
    chk("clock select mask", 24'h07, 24'(b));
    rd(5'h05, b);
    chk("signal select mask", 24'h1F, 24'(b));
    rd(5'h15, b);
    chk("unmapped", 24'h0, 24'(b));
    for (int a = 0; a < 6; a++) begin
      wr(5'(a), 8'h00);
    end
  endtask
  task automatic t_timer;
    int n;
    wr(5'h09, 8'h05);
    wr(5'h0A, 8'h00);
    wr(5'h0B, 8'h00);
    for (int c = 0; c < 2; c++) begin
      for (int p = 0; p < 4; p++) begin
        wr(5'h03, 8'(c * 2));
        wr(5'h00, 8'h80 | 8'(p));
        wr(5'h01, 8'h80);
        @(posedge i_clk);
        #1 chk("clock request", 24'h1, 24'(clk_req));
        wait_ev(0, n);
        wait_ev(0, n);
        chk("match spacing", 24'(6 * (4 << (2 * c)) * (1 << p)), 24'(n));
        wr(5'h00, 8'h00);
        @(posedge i_clk);
        #1 chk("request dropped", 24'h0, 24'(clk_req));
      end
    end
  endtask
  task automatic t_halt;
    int n;
    logic [23:0] v;
    logic [7:0] b;
    wr(5'h03, 8'h00);
    wr(5'h00, 8'hA0);
    wr(5'h01, 8'h80);
    wait_ev(0, n);
    rd24(5'h06, v);
    chk("held count", 24'h000005, v);
    wr(5'h00, 8'h20);
    rd(5'h01, b);
    chk("control_b kept", 24'h80, 24'(b));
    rd24(5'h09, v);
    chk("period kept", 24'h000005, v);
    wr(5'h02, 8'h20);
    wr(5'h01, 8'h00);
    wr(5'h00, 8'hA0);
    rd24(5'h06, v);
    chk("count cleared", 24'h0, v);
    rd(5'h02, b);
    chk("status idle", 24'h0, 24'(b));
    wr(5'h06, 8'h56);
    wr(5'h07, 8'h34);
    wr(5'h08, 8'h12);
    wr(5'h02, 8'hC0);
    wait_ev(1, n);
    chk("update in time", 24'h1, 24'(n < 8));
    rd24(5'h0C, v);
    chk("captured period", 24'h123456, v);
    rd24(5'h0F, v);
    chk("captured width", 24'h123456, v);
    rd(5'h02, b);
    chk("requests done", 24'h0, 24'(b));
  endtask
  task automatic t_capture;
    int n;
    logic [7:0] b;
    @(posedge i_clk);
    wcode <= 5'h09;
    wr(5'h04, 8'h09);
    wr(5'h00, 8'h80);
    wr(5'h01, 8'h87);
    @(posedge i_clk);
    wlvl <= 1'b1;
    wait_ev(1, n);
    chk("rise captures", 24'h1, 24'(n < 20));
    rd(5'h01, b);
    chk("single run ends", 24'h07, 24'(b));
    rd(5'h02, b);
    chk("window open", 24'h1, 24'(b[1]));
    wr(5'h00, 8'h90);
    wr(5'h01, 8'hC7);
    @(posedge i_clk);
    wlvl <= 1'b0;
    wait_ev(1, n);
    chk("low captures", 24'h1, 24'(n < 20));
    @(posedge i_clk);
    wlvl <= 1'b1;
    wait_ev(2, n);
    chk("width capture", 24'h1, 24'(n < 20));
    rd(5'h02, b);
    chk("acquiring", 24'h1, 24'(b[0]));
    rd(5'h01, b);
    chk("repeat keeps run", 24'hC7, 24'(b));
    wr(5'h00, 8'h00);
  endtask
  // counter mode counts synchronised signal rises, pulses held three cycles each way
  task automatic t_counter;
    logic [23:0] v;
    @(posedge i_clk);
    scode <= 5'h06;
    wr(5'h05, 8'h06);
    wr(5'h00, 8'h80);
    wr(5'h01, 8'hC8);
    wr(5'h02, 8'h20);
    repeat (3) begin
      @(posedge i_clk);
      slvl <= 1'b1;
      repeat (3) @(posedge i_clk);
      slvl <= 1'b0;
      repeat (2) @(posedge i_clk);
    end
    repeat (4) @(posedge i_clk);
    rd24(5'h06, v);
    chk("signal edges counted", 24'h000003, v);
    wr(5'h00, 8'h00);
  endtask
  task automatic close_out;
    $display("mismatches %0d checks %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ------
  // clock, watchdog, main sequence
  // ------
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  initial begin
    #(100 * 30000);
    err_total++;
    close_out();
  end
  initial begin
    i_rst_b = 1'b0;
    bus = '0;
    wcode = 5'h00;
    scode = 5'h00;
    wlvl = 1'b0;
    slvl = 1'b0;
    err_total = 0;
    n_tests = 0;
    repeat (10) @(posedge i_clk);
    i_rst_b <= 1'b1;
    t_regs();
    t_timer();
    t_halt();
    t_capture();
    t_counter();
    close_out();
  end
endmodule
bind smc_measure_ctrl smc_measure_ctrl_chk smc_measure_ctrl_chk_i (.i_clk(i_clk),
  .i_rst_b(i_rst_b), .i_bus(i_bus), .o_rdata(o_rdata), .o_clk_req(o_clk_req),
  .o_period_match(o_period_match), .o_pr_capture(o_pr_capture),
  .o_pw_capture(o_pw_capture));
